//--- rtl/fsro_pkg.sv
// package of constants and types for the startup and readback option block
package fsro_pkg;
   // register bus
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam logic [7:0]  OPT_OFFSET      = 8'h00;
   localparam logic [7:0]  STAT_OFFSET     = 8'h04;
   localparam logic [7:0]  CRC_OFFSET      = 8'h08;

   // option register field positions
   localparam int          F_STARTUP_CLK   = 0;
   localparam int          F_WAIT_DONE     = 1;
   localparam int          F_DONE_EV_LO    = 2;
   localparam int          F_DONE_EV_HI    = 4;
   localparam int          F_REL_EV_LO     = 5;
   localparam int          F_REL_EV_HI     = 8;
   localparam int          F_RB_EN         = 9;
   localparam int          F_RB_ABORT      = 10;
   localparam int          F_RB_CLK        = 11;
   localparam int          F_RATE_LO       = 12;
   localparam int          F_RATE_HI       = 13;
   localparam int          F_CRC_EN        = 14;
   localparam int          F_SCAN_RECFG    = 15;
   localparam int          F_SCAN_RB       = 16;
   localparam int          OPT_W           = 17;
   localparam logic [16:0] OPT_RESET       = 17'h04000;

   // done event codes
   localparam logic [2:0]  DONE_C1         = 3'h0;
   localparam logic [2:0]  DONE_C2         = 3'h1;
   localparam logic [2:0]  DONE_C3         = 3'h2;
   localparam logic [2:0]  DONE_C4         = 3'h3;
   localparam logic [2:0]  DONE_U2         = 3'h4;
   localparam logic [2:0]  DONE_U3         = 3'h5;
   localparam logic [2:0]  DONE_U4         = 3'h6;

   // output release event codes
   localparam logic [3:0]  REL_C2          = 4'h0;
   localparam logic [3:0]  REL_C3          = 4'h1;
   localparam logic [3:0]  REL_C4          = 4'h2;
   localparam logic [3:0]  REL_U2          = 4'h3;
   localparam logic [3:0]  REL_U3          = 4'h4;
   localparam logic [3:0]  REL_U4          = 4'h5;
   localparam logic [3:0]  REL_DI          = 4'h6;
   localparam logic [3:0]  REL_DI_P1       = 4'h7;
   localparam logic [3:0]  REL_DI_P2       = 4'h8;

   // configuration clock rates
   localparam logic [1:0]  RATE_SLOW       = 2'h0;
   localparam logic [1:0]  RATE_MED        = 2'h1;
   localparam logic [1:0]  RATE_FAST       = 2'h2;
   localparam int          CLK_HZ          = 100_000_000;
   localparam int          SLOW_HZ         = 750_000;
   localparam int          MED_HZ          = 6_000_000;
   localparam int          FAST_HZ         = 12_000_000;
   localparam logic [7:0]  HALF_SLOW       = 8'(CLK_HZ / (2 * SLOW_HZ));
   localparam logic [7:0]  HALF_MED        = 8'(CLK_HZ / (2 * MED_HZ));
   localparam logic [7:0]  HALF_FAST       = 8'(CLK_HZ / (2 * FAST_HZ));

   // checksum and readback
   localparam logic [15:0] CRC_POLY        = 16'h8005;
   localparam logic [15:0] CRC_INIT        = 16'h0000;
   localparam logic [11:0] RB_BITS         = 12'h010;

   // startup sequencer states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_STARTUP = 3'b010,
      ST_DONE    = 3'b100
   } fsro_state_e;
endpackage

//--- rtl/fsro_cclk_gen.sv
// configuration clock generator dividing the system clock to the selected rate
`timescale 1ns/1ps
module fsro_cclk_gen
   import fsro_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [1:0] rate_sel,
   output logic            cclk_r,
   output logic            rise_r
);
   import fsro_pkg::*;

   logic [7:0] cnt_r;
   logic [7:0] half;

   // half period for the chosen rate, slow for any unused code
   always_comb begin
      case (rate_sel)
         RATE_MED:  half = HALF_MED;
         RATE_FAST: half = HALF_FAST;
         default:   half = HALF_SLOW;
      endcase
   end

   // divider toggles the clock level and flags each rising edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r  <= 8'h00;
         cclk_r <= 1'b0;
         rise_r <= 1'b0;
      end else if (cnt_r >= half - 8'h01) begin
         cnt_r  <= 8'h00;
         cclk_r <= ~cclk_r;
         rise_r <= ~cclk_r;
      end else begin
         cnt_r  <= cnt_r + 8'h01;
         rise_r <= 1'b0;
      end
   end
endmodule

//--- rtl/fsro_startup.sv
// startup sequencer with readback, checksum and scan options
// Notes on behaviour
// - startup clocked by configuration clock or user clock; configuration clock default
// - with sync option set, progression past the first edge holds until external done input is high
// - done asserted on selected configuration edge one to four; first edge default
// - with user clock, done on user edge two to four, counted after first edge
// - allowed done choices depend on clock select and sync; others fall back
// - readback request starts a readback only when readback is enabled; disabled by default
// - a running readback may be aborted only when abort is enabled
// - readback shift clock is configuration clock or user net; configuration default
// - when the clock pin is an output it is driven from the oscillator
// - configuration clock rate slow, medium or fast; slow by default
// - reconfiguration through scan port accepted only when enabled
// - readback through scan port permitted only when enabled
// - outputs released at selected edge or done input event; second edge default
`timescale 1ns/1ps
module fsro_startup
   import fsro_pkg::*;
(
   input  wire logic                    CLK,
   input  wire logic                    RESET,
   input  wire logic [fsro_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [fsro_pkg::DATA_W-1:0] WDATA,
   input  wire logic                    WR,
   input  wire logic                    RD,
   output logic [fsro_pkg::DATA_W-1:0]  RDATA,
   input  wire logic                    CCLK_IS_OUTPUT,
   input  wire logic                    CCLK_IN,
   output logic                         CCLK_OUT,
   output logic                         CCLK_OE,
   input  wire logic                    USER_CLK,
   input  wire logic                    READBACK_USER_CLK,
   input  wire logic                    LENGTH_COUNT_MET,
   input  wire logic                    EXTERNAL_DONE_IN,
   output logic                         DONE_OUT,
   output logic                         OUTPUTS_RELEASED,
   input  wire logic                    CFG_START,
   input  wire logic                    CFG_DATA,
   input  wire logic                    CFG_DATA_VALID,
   input  wire logic                    CFG_CRC_CHECK,
   output logic                         CRC_ERROR,
   input  wire logic                    READBACK_REQ,
   input  wire logic                    SCAN_READBACK_REQ,
   input  wire logic                    READBACK_ABORT,
   output logic                         READBACK_BUSY,
   output logic                         READBACK_SHIFT,
   input  wire logic                    SCAN_RECONFIG_REQ,
   output logic                         RECONFIG_START
);
   import fsro_pkg::*;

   fsro_state_e         state_r;
   fsro_state_e         state_nxt;
   logic [OPT_W-1:0]    opt_r;
   logic [2:0]          c_cnt_r;
   logic [2:0]          c_cnt_nxt;
   logic [2:0]          u_cnt_r;
   logic [2:0]          u_cnt_nxt;
   logic [2:0]          d_cnt_r;
   logic [2:0]          d_cnt_nxt;
   logic                di_seen_r;
   logic                cclk_in_d_r;
   logic                uclk_d_r;
   logic                rclk_d_r;
   logic                gen_cclk;
   logic                gen_rise;
   logic                cfg_edge;
   logic                user_edge;
   logic                rb_user_edge;
   logic                start_edge;
   logic                may_go;
   logic [2:0]          done_sel;
   logic [3:0]          rel_sel;
   logic                done_ok;
   logic                rel_ok;
   logic                done_hit;
   logic                rel_hit;
   logic [15:0]         crc_r;
   logic [11:0]         rb_cnt_r;
   logic                rb_shift;

   // option fields
   wire                 opt_user_clk  = opt_r[F_STARTUP_CLK];
   wire                 opt_sync      = opt_r[F_WAIT_DONE];
   wire [2:0]           opt_done_ev   = opt_r[F_DONE_EV_HI:F_DONE_EV_LO];
   wire [3:0]           opt_rel_ev    = opt_r[F_REL_EV_HI:F_REL_EV_LO];
   wire [1:0]           opt_rate      = opt_r[F_RATE_HI:F_RATE_LO];

   // true when a done code is legal for the clock and sync settings
   function automatic logic done_legal(input logic [2:0] ev, input logic uclk,
                                       input logic sync);
      logic ok;
      ok = 1'b0;
      case ({uclk, sync})
         2'b01:   ok = (ev <= DONE_C3);
         2'b00:   ok = (ev <= DONE_C4);
         2'b11:   ok = (ev == DONE_C1) || (ev == DONE_U2);
         2'b10:   ok = (ev == DONE_C1) || ((ev >= DONE_U2) && (ev <= DONE_U4));
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // true when a release code is legal for the clock and sync settings
   function automatic logic rel_legal(input logic [3:0] ev, input logic uclk,
                                      input logic sync);
      logic ok;
      ok = 1'b0;
      case ({uclk, sync})
         2'b01:   ok = (ev == REL_C2) || (ev == REL_C3) || (ev == REL_DI)
                       || (ev == REL_DI_P1);
         2'b00:   ok = (ev <= REL_C4);
         2'b11:   ok = (ev == REL_U2) || ((ev >= REL_DI) && (ev <= REL_DI_P2));
         2'b10:   ok = (ev >= REL_U2) && (ev <= REL_U4);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // configuration clock generator
   fsro_cclk_gen u_cclk (
      .clk      (CLK),
      .reset    (RESET),
      .rate_sel (opt_rate),
      .cclk_r   (gen_cclk),
      .rise_r   (gen_rise)
   );

   // previous levels of sampled clock inputs for edge detection
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         cclk_in_d_r <= 1'b0;
         uclk_d_r    <= 1'b0;
         rclk_d_r    <= 1'b0;
      end else begin
         cclk_in_d_r <= CCLK_IN;
         uclk_d_r    <= USER_CLK;
         rclk_d_r    <= READBACK_USER_CLK;
      end
   end

   // edge pulses for configuration, user and readback clocks
   assign cfg_edge     = CCLK_IS_OUTPUT ? gen_rise : (CCLK_IN & ~cclk_in_d_r);
   assign user_edge    = USER_CLK & ~uclk_d_r;
   assign rb_user_edge = READBACK_USER_CLK & ~rclk_d_r;
   assign start_edge   = opt_user_clk ? user_edge : cfg_edge;

   // pin drive from the oscillator when the pin is an output
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         CCLK_OUT <= 1'b0;
         CCLK_OE  <= 1'b0;
      end else begin
         CCLK_OUT <= gen_cclk;
         CCLK_OE  <= CCLK_IS_OUTPUT;
      end
   end

   // options take writes only while no startup is running
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         opt_r <= OPT_RESET;
      end else if (WR && (ADDR == OPT_OFFSET) && (state_r != ST_STARTUP)) begin
         opt_r <= WDATA[OPT_W-1:0];
      end
   end

   // illegal choices fall back to the default events
   always_comb begin
      done_ok  = done_legal(opt_done_ev, opt_user_clk, opt_sync);
      rel_ok   = rel_legal(opt_rel_ev, opt_user_clk, opt_sync);
      done_sel = done_ok ? opt_done_ev : DONE_C1;
      rel_sel  = rel_ok ? opt_rel_ev : REL_C2;
   end

   // progression past the first edge waits on the external done input
   assign may_go = ~opt_sync | EXTERNAL_DONE_IN;

   // edge counters after the length count is met
   always_comb begin
      c_cnt_nxt = c_cnt_r;
      u_cnt_nxt = u_cnt_r;
      d_cnt_nxt = d_cnt_r;
      if (state_r == ST_STARTUP) begin
         if (cfg_edge && (c_cnt_r != 3'h7) && ((c_cnt_r == 3'h0) || may_go)) begin
            c_cnt_nxt = c_cnt_r + 3'h1;
         end
         if (user_edge && (c_cnt_r != 3'h0) && (u_cnt_r != 3'h7) && may_go) begin
            u_cnt_nxt = u_cnt_r + 3'h1;
         end
         if (start_edge && di_seen_r && (d_cnt_r != 3'h7)) begin
            d_cnt_nxt = d_cnt_r + 3'h1;
         end
      end
   end

   // selected events reached at this edge
   always_comb begin
      done_hit = 1'b0;
      rel_hit  = 1'b0;
      if (state_r == ST_STARTUP) begin
         case (done_sel)
            DONE_U2: done_hit = (u_cnt_nxt >= 3'h2);
            DONE_U3: done_hit = (u_cnt_nxt >= 3'h3);
            DONE_U4: done_hit = (u_cnt_nxt >= 3'h4);
            default: done_hit = (c_cnt_nxt >= done_sel + 3'h1);
         endcase
         case (rel_sel)
            REL_C3:    rel_hit = (c_cnt_nxt >= 3'h3);
            REL_C4:    rel_hit = (c_cnt_nxt >= 3'h4);
            REL_U2:    rel_hit = (u_cnt_nxt >= 3'h2);
            REL_U3:    rel_hit = (u_cnt_nxt >= 3'h3);
            REL_U4:    rel_hit = (u_cnt_nxt >= 3'h4);
            REL_DI:    rel_hit = EXTERNAL_DONE_IN;
            REL_DI_P1: rel_hit = (d_cnt_nxt >= 3'h1);
            REL_DI_P2: rel_hit = (d_cnt_nxt >= 3'h2);
            default:   rel_hit = (c_cnt_nxt >= 3'h2);
         endcase
      end
   end

   // sequencer state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (LENGTH_COUNT_MET) begin
               state_nxt = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if ((DONE_OUT || done_hit) && (OUTPUTS_RELEASED || rel_hit)) begin
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: state_nxt = ST_DONE;
         default: state_nxt = ST_IDLE;
      endcase
      if (SCAN_RECONFIG_REQ && opt_r[F_SCAN_RECFG]) begin
         state_nxt = ST_IDLE;
      end
   end

   // state, counters and startup outputs
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_r          <= ST_IDLE;
         c_cnt_r          <= 3'h0;
         u_cnt_r          <= 3'h0;
         d_cnt_r          <= 3'h0;
         di_seen_r        <= 1'b0;
         DONE_OUT         <= 1'b0;
         OUTPUTS_RELEASED <= 1'b0;
      end else if (state_nxt == ST_IDLE) begin
         state_r          <= state_nxt;
         c_cnt_r          <= 3'h0;
         u_cnt_r          <= 3'h0;
         d_cnt_r          <= 3'h0;
         di_seen_r        <= 1'b0;
         DONE_OUT         <= 1'b0;
         OUTPUTS_RELEASED <= 1'b0;
      end else begin
         state_r          <= state_nxt;
         c_cnt_r          <= c_cnt_nxt;
         u_cnt_r          <= u_cnt_nxt;
         d_cnt_r          <= d_cnt_nxt;
         di_seen_r        <= di_seen_r | ((state_r == ST_STARTUP) & EXTERNAL_DONE_IN);
         DONE_OUT         <= DONE_OUT | done_hit;
         OUTPUTS_RELEASED <= OUTPUTS_RELEASED | rel_hit;
      end
   end

   // scan port reconfiguration start pulse
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         RECONFIG_START <= 1'b0;
      end else begin
         RECONFIG_START <= SCAN_RECONFIG_REQ & opt_r[F_SCAN_RECFG];
      end
   end

   // running checksum over serial configuration data
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         crc_r     <= CRC_INIT;
         CRC_ERROR <= 1'b0;
      end else if (CFG_START) begin
         crc_r     <= CRC_INIT;
         CRC_ERROR <= 1'b0;
      end else begin
         if (CFG_DATA_VALID) begin
            crc_r <= {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ CFG_DATA) ? CRC_POLY : 16'h0000);
         end
         if (CFG_CRC_CHECK && opt_r[F_CRC_EN] && (crc_r != 16'h0000)) begin
            CRC_ERROR <= 1'b1;
         end
      end
   end

   // readback shift clock source
   assign rb_shift = opt_r[F_RB_CLK] ? rb_user_edge : cfg_edge;

   // readback sequence with optional abort
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         READBACK_BUSY  <= 1'b0;
         READBACK_SHIFT <= 1'b0;
         rb_cnt_r       <= 12'h000;
      end else if (!READBACK_BUSY) begin
         READBACK_SHIFT <= 1'b0;
         rb_cnt_r       <= 12'h000;
         if ((READBACK_REQ && opt_r[F_RB_EN]) ||
             (SCAN_READBACK_REQ && opt_r[F_SCAN_RB])) begin
            READBACK_BUSY <= 1'b1;
         end
      end else if (READBACK_ABORT && opt_r[F_RB_ABORT]) begin
         READBACK_BUSY  <= 1'b0;
         READBACK_SHIFT <= 1'b0;
      end else begin
         READBACK_SHIFT <= rb_shift;
         if (rb_shift) begin
            rb_cnt_r <= rb_cnt_r + 12'h001;
            if (rb_cnt_r == RB_BITS - 12'h001) begin
               READBACK_BUSY <= 1'b0;
            end
         end
      end
   end

   // register read data one cycle after the strobe
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         RDATA <= 32'h00000000;
      end else if (RD) begin
         case (ADDR)
            OPT_OFFSET:  RDATA <= {15'h0000, opt_r};
            STAT_OFFSET: RDATA <= {22'h000000, ~rel_ok, ~done_ok, CRC_ERROR,
                                   READBACK_BUSY, 1'b0, state_r,
                                   OUTPUTS_RELEASED, DONE_OUT};
            CRC_OFFSET:  RDATA <= {16'h0000, crc_r};
            default:     RDATA <= 32'h00000000;
         endcase
      end else begin
         RDATA <= 32'h00000000;
      end
   end
endmodule

//--- verif/fsro_startup_sva.sv
// assertion checker for the startup and readback option block
`timescale 1ns/1ps
module fsro_startup_sva (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CCLK_IS_OUTPUT,
   input wire logic CCLK_OE,
   input wire logic DONE_OUT,
   input wire logic OUTPUTS_RELEASED,
   input wire logic READBACK_REQ,
   input wire logic SCAN_READBACK_REQ,
   input wire logic READBACK_BUSY,
   input wire logic READBACK_SHIFT,
   input wire logic SCAN_RECONFIG_REQ,
   input wire logic RECONFIG_START
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // pin driver enable tracks the pin mode
   AST_OE_MODE:
      assert property (!$past(RESET) |-> CCLK_OE == $past(CCLK_IS_OUTPUT))
      else $error("pin enable wrong");
   // done and release hold until a scan reconfiguration
   AST_DONE_HOLD:
      assert property (DONE_OUT && !SCAN_RECONFIG_REQ |=> DONE_OUT)
      else $error("done dropped");
   AST_REL_HOLD:
      assert property (OUTPUTS_RELEASED && !SCAN_RECONFIG_REQ |=> OUTPUTS_RELEASED)
      else $error("release dropped");
   // reconfiguration start is a single pulse that clears startup results
   AST_RECFG_CLR:
      assert property (RECONFIG_START |=> !RECONFIG_START && !DONE_OUT && !OUTPUTS_RELEASED)
      else $error("reconfig did not clear");
   AST_RECFG_CAUSE:
      assert property (RECONFIG_START |-> $past(SCAN_RECONFIG_REQ))
      else $error("reconfig without request");
   // readback starts only on a request and shifts only while busy
   AST_BUSY_CAUSE:
      assert property ($rose(READBACK_BUSY) |-> $past(READBACK_REQ) || $past(SCAN_READBACK_REQ))
      else $error("busy without request");
   AST_SHIFT_BUSY:
      assert property (READBACK_SHIFT |-> $past(READBACK_BUSY))
      else $error("shift while idle");
   AST_SHIFT_PULSE:
      assert property (READBACK_SHIFT |=> !READBACK_SHIFT)
      else $error("shift longer than one cycle");
   // main scenarios reached
   cover property ($rose(DONE_OUT));
   cover property ($fell(READBACK_BUSY));
   cover property (RECONFIG_START);
endmodule
bind fsro_startup fsro_startup_sva fsro_startup_sva_i (
   .CLK, .RESET, .CCLK_IS_OUTPUT, .CCLK_OE, .DONE_OUT, .OUTPUTS_RELEASED, .READBACK_REQ,
   .SCAN_READBACK_REQ, .READBACK_BUSY, .READBACK_SHIFT, .SCAN_RECONFIG_REQ, .RECONFIG_START
);

//--- verif/fsro_cfg_src.sv
// configuration source model: clock pin and user clock, low while stopped
`timescale 1ns/1ps
module fsro_cfg_src (
   input  wire logic clk,
   input  wire logic run_c,
   input  wire logic run_u,
   output logic      cclk_pin,
   output logic      uclk
);
   int cc = 0;
   int uc = 0;
   initial {cclk_pin, uclk} = 2'b00;
   // pin clock toggles every third cycle inside a frame
   always @(posedge clk) begin
      cc <= (run_c && cc < 2) ? cc + 1 : 0;
      cclk_pin <= run_c && (cc == 2 ? !cclk_pin : cclk_pin);
   end
   // user clock toggles every second cycle while enabled
   always @(posedge clk) begin
      uc <= (run_u && uc < 1) ? uc + 1 : 0;
      uclk <= run_u && (uc == 1 ? !uclk : uclk);
   end
endmodule

//--- verif/fsro_startup_tb.sv
// self-checking bench for the startup and readback option block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 400) begin @(posedge clk); #1; k++; end \
   if (!(c)) begin n_fail++; end_sim; end end
module fsro_startup_tb;
   import fsro_pkg::*;
   localparam int LCM = 0, CST = 1, CCK = 2, RBQ = 3, SRB = 4, ABT = 5, SRC = 6, VAL = 7;
   localparam logic [7:0] DAT = 8'ha5;
   logic        clk, rst, wr_s, rd_s, cio, ext_done, cfg_bit, run_c, run_u;
   logic        cclk_oe, cclk_pin, uclk, done_out, rel, crc_err, busy, shift, reconf, cclk_out;
   logic [7:0]  addr, stb;
   logic [31:0] wdata, rdata, v;
   int          n_fail, tests_run, k, e;

   fsro_startup fsro_startup_i (
      .CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .CCLK_IS_OUTPUT(cio), .CCLK_IN(cclk_pin), .CCLK_OUT(cclk_out),
      .CCLK_OE(cclk_oe), .USER_CLK(uclk), .READBACK_USER_CLK(uclk),
      .LENGTH_COUNT_MET(stb[LCM]), .EXTERNAL_DONE_IN(ext_done), .DONE_OUT(done_out),
      .OUTPUTS_RELEASED(rel), .CFG_START(stb[CST]), .CFG_DATA(cfg_bit),
      .CFG_DATA_VALID(stb[VAL]), .CFG_CRC_CHECK(stb[CCK]), .CRC_ERROR(crc_err),
      .READBACK_REQ(stb[RBQ]), .SCAN_READBACK_REQ(stb[SRB]), .READBACK_ABORT(stb[ABT]),
      .READBACK_BUSY(busy), .READBACK_SHIFT(shift), .SCAN_RECONFIG_REQ(stb[SRC]),
      .RECONFIG_START(reconf)
   );
   fsro_cfg_src fsro_cfg_src_i (
      .clk(clk), .run_c(run_c), .run_u(run_u), .cclk_pin(cclk_pin), .uclk(uclk)
   );

   // bus cycles, strobes and reset
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rdv(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      rdv(a, v);
      `CHK(v, x)
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      stb[b] <= 1'b1;
      @(posedge clk);
      stb[b] <= 1'b0;
   endtask
   task automatic settle;
      @(posedge clk);
      #1;
   endtask
   task automatic do_rst;
      @(posedge clk);
      rst <= 1'b1;
      ext_done <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask
   // counts rising edges of one clock until done shows
   task automatic cnt_to_done(input bit usr, output int n);
      logic p;
      p = usr ? uclk : cclk_pin;
      n = 0;
      for (k = 0; k < 400 && !done_out; k++) begin
         @(posedge clk);
         #1;
         if ((usr ? uclk : cclk_pin) && !p) n++;
         p = usr ? uclk : cclk_pin;
      end
      if (!done_out) begin
         n_fail++;
         end_sim;
      end
   endtask
   // reset values of the option and status registers and an unmapped read
   task automatic t_defaults;
      rdc(OPT_OFFSET, 32'h4000);
      rdc(STAT_OFFSET, 32'h4);
      rdc(8'h0c, 32'h0);
      $display("t_defaults end");
   endtask
   // illegal done and release choices flagged per clock and sync setting
   task automatic t_legal;
      logic [31:0] o [9] = '{32'h0c, 32'h0e, 32'h0a, 32'h73, 32'h77, 32'h79, 32'h10, 32'h60,
                             32'h1e3};
      logic [1:0]  b [9] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
      for (int i = 0; i < 9; i++) begin
         wr(OPT_OFFSET, o[i]);
         rdv(STAT_OFFSET, v);
         `CHK(v[9:8], b[i])
      end
      $display("t_legal end");
   endtask
   // done to release gap equals one internal clock period at each rate
   task automatic t_rates;
      int per [3] = '{132, 16, 8};
      for (int r = 0; r < 3; r++) begin
         do_rst;
         cio <= 1'b1;
         wr(OPT_OFFSET, 32'h4000 | 32'(r << 12));
         pulse(LCM);
         `WAITC(done_out)
         `CHK(cclk_out, 1'b1)
         `WAITC(rel)
         `CHK(k, per[r])
         `CHK(cclk_oe, 1'b1)
         rdc(STAT_OFFSET, 32'h13);
      end
      $display("t_rates end");
   endtask
   // scan reconfiguration refused, then accepted
   task automatic t_reconf;
      do_rst;
      wr(OPT_OFFSET, 32'h6000);
      pulse(LCM);
      `WAITC(rel)
      pulse(SRC);
      settle;
      `CHK(done_out, 1'b1)
      wr(OPT_OFFSET, 32'he000);
      pulse(SRC);
      #1;
      `CHK(reconf, 1'b1)
      rdc(STAT_OFFSET, 32'h4);
      $display("t_reconf end");
   endtask
   // done on each pin clock edge one to four
   task automatic t_pin;
      for (int c = 0; c < 4; c++) begin
         do_rst;
         cio <= 1'b0;
         wr(OPT_OFFSET, 32'h4000 | 32'(c << 2));
         pulse(LCM);
         @(posedge clk);
         run_c <= 1'b1;
         cnt_to_done(1'b0, e);
         `CHK(e, c + 1)
         run_c <= 1'b0;
      end
      $display("t_pin end");
   endtask
   // done on the second user edge, none on pin edges alone
   task automatic t_user;
      do_rst;
      wr(OPT_OFFSET, 32'h4071);
      pulse(LCM);
      @(posedge clk);
      run_c <= 1'b1;
      repeat (30) settle;
      `CHK(done_out, 1'b0)
      @(posedge clk);
      run_u <= 1'b1;
      cnt_to_done(1'b1, e);
      `CHK(e, 2)
      run_c <= 1'b0;
      run_u <= 1'b0;
      $display("t_user end");
   endtask
   // progression held by the done input; option writes dropped meanwhile
   task automatic t_sync;
      do_rst;
      wr(OPT_OFFSET, 32'h4006);
      pulse(LCM);
      @(posedge clk);
      run_c <= 1'b1;
      repeat (40) settle;
      `CHK(done_out, 1'b0)
      wr(OPT_OFFSET, 32'h0);
      rdc(OPT_OFFSET, 32'h4006);
      @(posedge clk);
      run_c <= 1'b0;
      repeat (2) @(posedge clk);
      ext_done <= 1'b1;
      run_c <= 1'b1;
      cnt_to_done(1'b0, e);
      `CHK(e, 1)
      run_c <= 1'b0;
      $display("t_sync end");
   endtask
   // readback enable, user shift clock, abort and scan readback
   task automatic t_rb;
      do_rst;
      pulse(RBQ);
      pulse(SRB);
      settle;
      `CHK(busy, 1'b0)
      wr(OPT_OFFSET, 32'h4a00);
      pulse(RBQ);
      #1;
      `CHK(busy, 1'b1)
      pulse(ABT);
      settle;
      `CHK(busy, 1'b1)
      @(posedge clk);
      run_u <= 1'b1;
      e = 0;
      for (k = 0; k < 400 && busy; k++) begin
         @(posedge clk);
         #1;
         if (shift) e++;
      end
      `CHK(e, 16)
      if (busy) begin
         n_fail++;
         end_sim;
      end
      @(posedge clk);
      run_u <= 1'b0;
      wr(OPT_OFFSET, 32'h4e00);
      pulse(RBQ);
      #1;
      `CHK(busy, 1'b1)
      pulse(ABT);
      settle;
      `CHK(busy, 1'b0)
      wr(OPT_OFFSET, 32'h14000);
      pulse(SRB);
      #1;
      `CHK(busy, 1'b1)
      $display("t_rb end");
   endtask
   // serial checksum value, error flag, clear and disable
   task automatic send;
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk);
         cfg_bit <= DAT[i];
         stb[VAL] <= 1'b1;
      end
      @(posedge clk);
      stb[VAL] <= 1'b0;
   endtask
   task automatic t_crc;
      logic [15:0] c;
      logic        fb;
      c = 16'h0;
      for (int i = 7; i >= 0; i--) begin
         fb = c[15] ^ DAT[i];
         c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0);
      end
      do_rst;
      pulse(CST);
      send;
      rdc(CRC_OFFSET, {16'h0, c});
      pulse(CCK);
      settle;
      `CHK(crc_err, 1'b1)
      pulse(CST);
      settle;
      `CHK(crc_err, 1'b0)
      wr(OPT_OFFSET, 32'h0);
      send;
      pulse(CCK);
      settle;
      `CHK(crc_err, 1'b0)
      $display("t_crc end");
   endtask
   // verdict and end of run
   task automatic end_sim;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // main sequence
   initial begin
      rst = 1'b1;
      {wr_s, rd_s, cio, ext_done, cfg_bit, run_c, run_u} = 7'h0;
      addr = 8'h0;
      stb = 8'h0;
      wdata = 32'h0;
      n_fail = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      t_legal;
      t_rates;
      t_reconf;
      t_pin;
      t_user;
      t_sync;
      t_rb;
      t_crc;
      end_sim;
   end
endmodule
